/* inc/tedet_pkg.sv */
// Constants and carrier types for the tunnel escape detector
package tedet_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite slave)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W       = 8;
    localparam logic [7:0]  OFF_SWITCH   = 8'h00;
    localparam logic [7:0]  OFF_LENGTH   = 8'h04;
    localparam logic [7:0]  OFF_PAT_LO   = 8'h08;
    localparam logic [7:0]  OFF_PAT_HI   = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0]  OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0]  OFF_STATUS   = 8'h18;
    localparam logic [7:0]  OFF_COUNT    = 8'h1c;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SWITCH_BIT     = 0;
    localparam logic        SWITCH_DISABLE = 1'b0;
    localparam logic        SWITCH_ENABLE  = 1'b1;
    localparam logic        SWITCH_RST     = SWITCH_DISABLE;
    localparam logic [31:0] LENGTH_RST     = 32'h0000_0000;
    localparam logic [63:0] PATTERN_RST    = 64'h0;
    localparam logic [31:0] LEN_MIN        = 32'h0000_0001;
    localparam logic [31:0] LEN_MAX        = 32'h0000_0008;
    localparam int unsigned PAT_BYTES      = 8;
    localparam logic [3:0]  FILL_MAX       = 4'h8;
    localparam int unsigned STATUS_DEAD_LSB = 16;

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       vld;
        logic [7:0] data;
    } tedet_byte_t;

endpackage

/* hdl/tedet_top.sv */
// Tunnel escape detector: per-tunnel pattern matcher with AXI4-Lite registers
`timescale 1ns/1ns

module tedet_top #(
    parameter int unsigned NUM_TUN = 2
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       reset_i,
    // AXI4-Lite slave
    input  wire logic [7:0]                 s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output logic                            s_axi_awready_o,
    input  wire logic [31:0]                s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output logic                            s_axi_wready_o,
    output logic [1:0]                      s_axi_bresp_o,
    output logic                            s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic [7:0]                 s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output logic                            s_axi_arready_o,
    output logic [31:0]                     s_axi_rdata_o,
    output logic [1:0]                      s_axi_rresp_o,
    output logic                            s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i,
    // Tunnels: index 2*t is port A to port B, 2*t+1 is port B to port A
    input  wire logic [NUM_TUN-1:0]         tunnel_active_i,
    input  tedet_pkg::tedet_byte_t [2*NUM_TUN-1:0] rx_byte_i,
    output tedet_pkg::tedet_byte_t [2*NUM_TUN-1:0] tx_byte_o,
    output logic [NUM_TUN-1:0]              port_interface_mode_command_o,
    output logic                            irq_o
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Merge a bus write into a 32-bit word under its byte enables
    function automatic logic [31:0] tedet_merge(input logic [31:0] old_val,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  wstrb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (wstrb[b]) begin
                res[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return res;
    endfunction

    // True when the newest byte completes the pattern. The window is the
    // new byte plus the seven bytes before it, newest in the low byte, so
    // every alignment is tested each byte and overlapping prefixes survive.
    function automatic logic tedet_hit(input logic [63:0] hist,
                                       input logic [7:0]  newb,
                                       input logic [3:0]  fill,
                                       input logic [63:0] pat,
                                       input logic [3:0]  len);
        logic [63:0] win;
        logic        ok;
        win = {hist[55:0], newb};
        ok  = ({1'b0, fill} + 5'h01) >= {1'b0, len};
        for (int k = 0; k < tedet_pkg::PAT_BYTES; k++) begin
            if (k < int'(len)) begin
                ok = ok & (win[8*k +: 8] == pat[8*(int'(len) - 1 - k) +: 8]);
            end
        end
        return ok;
    endfunction

    // Word address with the byte lane bits dropped
    function automatic logic [7:0] tedet_word(input logic [7:0] addr);
        return {addr[7:2], 2'b00};
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                       switch_ff;
    logic [31:0]                length_ff;
    logic [63:0]                pattern_ff;
    logic [NUM_TUN-1:0]         irq_stat_ff;
    logic [NUM_TUN-1:0]         irq_mask_ff;
    logic [31:0]                count_ff;
    logic                       irq_ff;

    logic                       awready_ff;
    logic                       wready_ff;
    logic                       aw_got_ff;
    logic                       w_got_ff;
    logic [7:0]                 awaddr_ff;
    logic [31:0]                wdata_ff;
    logic [3:0]                 wstrb_ff;
    logic                       bvalid_ff;
    logic [1:0]                 bresp_ff;
    logic                       arready_ff;
    logic                       rvalid_ff;
    logic [31:0]                rdata_ff;
    logic [1:0]                 rresp_ff;

    logic [63:0]                hist_ff [2*NUM_TUN];
    logic [3:0]                 fill_ff [2*NUM_TUN];
    tedet_pkg::tedet_byte_t [2*NUM_TUN-1:0] fwd_ff;
    logic [NUM_TUN-1:0]         dead_ff;
    logic [NUM_TUN-1:0]         hit_q_ff;
    logic [NUM_TUN-1:0]         mode_cmd_ff;

    logic                       aw_fire;
    logic                       w_fire;
    logic                       b_fire;
    logic                       ar_fire;
    logic                       r_fire;
    logic                       do_write;
    logic [7:0]                 wr_addr;
    logic                       len_ok;
    logic [NUM_TUN-1:0]         live;
    logic [2*NUM_TUN-1:0]       hit_dir;
    logic [NUM_TUN-1:0]         tunnel_hit;
    logic [NUM_TUN-1:0]         rd_clear;
    logic [31:0]                rd_val;
    logic [1:0]                 rd_resp;
    logic [1:0]                 wr_resp;

    // ------------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------------
    assign aw_fire  = s_axi_awvalid_i & awready_ff;
    assign w_fire   = s_axi_wvalid_i & wready_ff;
    assign b_fire   = bvalid_ff & s_axi_bready_i;
    assign ar_fire  = s_axi_arvalid_i & arready_ff;
    assign r_fire   = rvalid_ff & s_axi_rready_i;
    assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
    assign wr_addr  = tedet_word(awaddr_ff);

    // Address and data are taken in either order; each ready drops once
    // its item is held and rises again only after the response is taken.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            if (aw_fire) begin
                awready_ff <= 1'b0;
                aw_got_ff  <= 1'b1;
                awaddr_ff  <= s_axi_awaddr_i;
            end else if (do_write) begin
                aw_got_ff  <= 1'b0;
            end else if (b_fire) begin
                awready_ff <= 1'b1;
            end
            if (w_fire) begin
                wready_ff <= 1'b0;
                w_got_ff  <= 1'b1;
                wdata_ff  <= s_axi_wdata_i;
                wstrb_ff  <= s_axi_wstrb_i;
            end else if (do_write) begin
                w_got_ff  <= 1'b0;
            end else if (b_fire) begin
                wready_ff <= 1'b1;
            end
        end
    end

    always_comb begin
        unique case (wr_addr)
            tedet_pkg::OFF_SWITCH,
            tedet_pkg::OFF_LENGTH,
            tedet_pkg::OFF_PAT_LO,
            tedet_pkg::OFF_PAT_HI,
            tedet_pkg::OFF_IRQ_MASK: wr_resp = tedet_pkg::RESP_OKAY;
            default:                 wr_resp = tedet_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= tedet_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_resp;
        end else if (b_fire) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Software must write a length and that many pattern bytes before
    // setting the switch; mid-update values are matched as they stand.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            switch_ff   <= tedet_pkg::SWITCH_RST;
            length_ff   <= tedet_pkg::LENGTH_RST;
            pattern_ff  <= tedet_pkg::PATTERN_RST;
            irq_mask_ff <= '0;
        end else if (do_write) begin
            unique case (wr_addr)
                tedet_pkg::OFF_SWITCH: begin
                    if (wstrb_ff[0]) begin
                        switch_ff <= wdata_ff[tedet_pkg::SWITCH_BIT];
                    end
                end
                tedet_pkg::OFF_LENGTH: begin
                    length_ff <= tedet_merge(length_ff, wdata_ff, wstrb_ff);
                end
                tedet_pkg::OFF_PAT_LO: begin
                    pattern_ff[31:0] <= tedet_merge(pattern_ff[31:0], wdata_ff, wstrb_ff);
                end
                tedet_pkg::OFF_PAT_HI: begin
                    pattern_ff[63:32] <= tedet_merge(pattern_ff[63:32], wdata_ff, wstrb_ff);
                end
                tedet_pkg::OFF_IRQ_MASK: begin
                    irq_mask_ff <= wdata_ff[NUM_TUN-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_val  = 32'h0000_0000;
        rd_resp = tedet_pkg::RESP_OKAY;
        unique case (tedet_word(s_axi_araddr_i))
            tedet_pkg::OFF_SWITCH:   rd_val[tedet_pkg::SWITCH_BIT] = switch_ff;
            tedet_pkg::OFF_LENGTH:   rd_val = length_ff;
            tedet_pkg::OFF_PAT_LO:   rd_val = pattern_ff[31:0];
            tedet_pkg::OFF_PAT_HI:   rd_val = pattern_ff[63:32];
            tedet_pkg::OFF_IRQ_STAT: rd_val[NUM_TUN-1:0] = irq_stat_ff;
            tedet_pkg::OFF_IRQ_MASK: rd_val[NUM_TUN-1:0] = irq_mask_ff;
            tedet_pkg::OFF_STATUS: begin
                rd_val[NUM_TUN-1:0] = live;
                rd_val[tedet_pkg::STATUS_DEAD_LSB +: NUM_TUN] = dead_ff;
            end
            tedet_pkg::OFF_COUNT:    rd_val = count_ff;
            default:                 rd_resp = tedet_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= tedet_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_val;
            rresp_ff   <= rd_resp;
        end else if (r_fire) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Escape matching
    // ------------------------------------------------------------------
    // A length outside one to eight never matches
    assign len_ok = (switch_ff == tedet_pkg::SWITCH_ENABLE)
                  & (length_ff >= tedet_pkg::LEN_MIN)
                  & (length_ff <= tedet_pkg::LEN_MAX);

    // A torn-down tunnel stays dead until its owner drops it, so stray
    // bytes cannot slip through between teardown and the mode change.
    assign live = tunnel_active_i & ~dead_ff;

    always_comb begin
        for (int d = 0; d < 2*NUM_TUN; d++) begin
            hit_dir[d] = len_ok & live[d/2] & rx_byte_i[d].vld
                       & tedet_hit(hist_ff[d], rx_byte_i[d].data, fill_ff[d],
                                   pattern_ff, length_ff[3:0]);
        end
        for (int t = 0; t < NUM_TUN; t++) begin
            tunnel_hit[t] = hit_dir[2*t] | hit_dir[2*t+1];
        end
    end

    // Each direction owns its history; nothing is shared across tunnels
    always_ff @(posedge clk_sys_i) begin
        for (int d = 0; d < 2*NUM_TUN; d++) begin
            if (reset_i) begin
                hist_ff[d] <= 64'h0;
                fill_ff[d] <= 4'h0;
            end else if (!live[d/2] || !len_ok || tunnel_hit[d/2]) begin
                hist_ff[d] <= 64'h0;
                fill_ff[d] <= 4'h0;
            end else if (rx_byte_i[d].vld) begin
                hist_ff[d] <= {hist_ff[d][55:0], rx_byte_i[d].data};
                if (fill_ff[d] != tedet_pkg::FILL_MAX) begin
                    fill_ff[d] <= fill_ff[d] + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Forwarding and teardown
    // ------------------------------------------------------------------
    // The matching byte goes out with the rest; the mode command follows
    // one cycle after it, so the pattern is the last thing forwarded.
    always_ff @(posedge clk_sys_i) begin
        for (int d = 0; d < 2*NUM_TUN; d++) begin
            if (reset_i || !live[d/2]) begin
                fwd_ff[d] <= '0;
            end else begin
                fwd_ff[d] <= rx_byte_i[d];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            dead_ff     <= '0;
            hit_q_ff    <= '0;
            mode_cmd_ff <= '0;
        end else begin
            dead_ff     <= (dead_ff | tunnel_hit) & tunnel_active_i;
            hit_q_ff    <= tunnel_hit;
            // One pulse per tunnel returns both its ports to command mode;
            // rate and framing outputs do not exist here, so they stay put.
            mode_cmd_ff <= hit_q_ff;
        end
    end

    // ------------------------------------------------------------------
    // Event status, counter and interrupt
    // ------------------------------------------------------------------
    assign rd_clear = (ar_fire && tedet_word(s_axi_araddr_i) == tedet_pkg::OFF_IRQ_STAT)
                    ? irq_stat_ff : '0;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            irq_stat_ff <= '0;
            count_ff    <= 32'h0000_0000;
            irq_ff      <= 1'b0;
        end else begin
            // A new hit in the clearing cycle survives the read
            irq_stat_ff <= (irq_stat_ff & ~rd_clear) | tunnel_hit;
            if (|tunnel_hit) begin
                count_ff <= count_ff + 32'h0000_0001;
            end
            irq_ff <= |(((irq_stat_ff & ~rd_clear) | tunnel_hit) & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o               = awready_ff;
    assign s_axi_wready_o                = wready_ff;
    assign s_axi_bvalid_o                = bvalid_ff;
    assign s_axi_bresp_o                 = bresp_ff;
    assign s_axi_arready_o               = arready_ff;
    assign s_axi_rvalid_o                = rvalid_ff;
    assign s_axi_rdata_o                 = rdata_ff;
    assign s_axi_rresp_o                 = rresp_ff;
    assign tx_byte_o                     = fwd_ff;
    assign port_interface_mode_command_o = mode_cmd_ff;
    assign irq_o                         = irq_ff;

endmodule

/* sim/tedet_sva.sv */
// Port-level checker for the tunnel escape detector
`timescale 1ns/1ns
module tedet_sva #(
    parameter int unsigned NUM_TUN = 2
) (
    input wire logic                                clk_sys_i,
    input wire logic                                reset_i,
    input wire logic                                s_axi_awready_o,
    input wire logic                                s_axi_wready_o,
    input wire logic                                s_axi_bvalid_o,
    input wire logic                                s_axi_bready_i,
    input wire logic                                s_axi_arvalid_i,
    input wire logic                                s_axi_arready_o,
    input wire logic                                s_axi_rvalid_o,
    input wire logic [NUM_TUN-1:0]                  tunnel_active_i,
    input wire tedet_pkg::tedet_byte_t [2*NUM_TUN-1:0] rx_byte_i,
    input wire tedet_pkg::tedet_byte_t [2*NUM_TUN-1:0] tx_byte_o,
    input wire logic [NUM_TUN-1:0]                  port_interface_mode_command_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // ------------------------------------------------------------------
    // Stream side
    // ------------------------------------------------------------------
    for (genvar d = 0; d < 2*NUM_TUN; d++) begin : g_dir
        chk_tx_copy: assert property (tx_byte_o[d].vld |-> $past(rx_byte_i[d].vld)
            && tx_byte_o[d].data == $past(rx_byte_i[d].data)) else $error("tx byte not a copy");
        chk_tx_idle: assert property (!$past(tunnel_active_i[d/2]) |-> tx_byte_o[d] == '0)
            else $error("tx active on idle tunnel");
    end
    for (genvar t = 0; t < NUM_TUN; t++) begin : g_tun
        chk_cmd_after_tx: assert property (port_interface_mode_command_o[t] |->
            $past(tx_byte_o[2*t].vld || tx_byte_o[2*t+1].vld)) else $error("command without byte");
        chk_cmd_single: assert property (port_interface_mode_command_o[t] |=>
            !port_interface_mode_command_o[t]) else $error("command longer than a pulse");
        chk_cmd_dead: assert property (port_interface_mode_command_o[t] |->
            !tx_byte_o[2*t].vld && !tx_byte_o[2*t+1].vld) else $error("byte after escape");
        chk_cmd_active: assert property (port_interface_mode_command_o[t] |->
            $past(tunnel_active_i[t], 2)) else $error("command on inactive tunnel");
    end
    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    chk_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
        s_axi_awready_o && s_axi_wready_o) else $error("write channels not reopened");
    chk_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o && !s_axi_arready_o) else $error("read not answered next cycle");
endmodule

bind tedet_top tedet_sva #(.NUM_TUN(NUM_TUN)) chk_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .tunnel_active_i(tunnel_active_i), .rx_byte_i(rx_byte_i), .tx_byte_o(tx_byte_o),
    .port_interface_mode_command_o(port_interface_mode_command_o));

/* sim/tedet_peer.sv */
// Serial equipment model that feeds bytes into the tunnel ports
`timescale 1ns/1ns
module tedet_peer #(
    parameter int unsigned NUM_TUN = 2
) (
    input  wire logic                              clk_sys_i,
    output tedet_pkg::tedet_byte_t [2*NUM_TUN-1:0] rx_byte_o
);
    initial rx_byte_o = '0;
    // Idle data is the inverse of the last byte so a stale value never looks valid
    task automatic send(input int dir, input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_sys_i);
            rx_byte_o[dir] <= '{vld: 1'b1, data: s[i]};
        end
        @(posedge clk_sys_i);
        rx_byte_o[dir] <= '{vld: 1'b0, data: ~rx_byte_o[dir].data};
    endtask
endmodule

/* sim/tb_tedet_top.sv */
// Self-checking bench for the tunnel escape detector
`timescale 1ns/1ns
module tb_tedet_top;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, mode;
    logic [1:0]  act = '0;
    tedet_pkg::tedet_byte_t [3:0] rx, tx;
    int          err_count = 0, tests_run = 0, mcnt [2] = '{0, 0}, tcnt [4] = '{0, 0, 0, 0};

    tedet_top #(.NUM_TUN(2)) dut_u (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .tunnel_active_i(act), .rx_byte_i(rx), .tx_byte_o(tx),
        .port_interface_mode_command_o(mode), .irq_o(irq));
    tedet_peer #(.NUM_TUN(2)) peer_u (.clk_sys_i(clk_sys_i), .rx_byte_o(rx));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        for (int i = 0; i < 4; i++) if (tx[i].vld === 1'b1) tcnt[i]++;
        for (int i = 0; i < 2; i++) if (mode[i] === 1'b1) mcnt[i]++;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    // Write when w is set, else read and compare the word against ed
    task automatic bus(input int w, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er, input logic [31:0] ed);
        @(posedge clk_sys_i);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (int k = 0; k < 41; k++) begin
            if (k == 40) begin
                $display("ERROR bus answer expected within 40 cycles seen none");
                err_count++;
                give_verdict();
            end
            @(posedge clk_sys_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (arready === 1'b1) arvalid <= 1'b0;
            if ((w ? bvalid : rvalid) === 1'b1) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        chk("resp", {30'h0, er}, {30'h0, w ? bresp : rresp});
        if (!w) chk("rdata", ed, rdata);
    endtask
    task automatic cfg(input logic [31:0] len, input logic [31:0] lo, input logic [31:0] hi,
                       input int sw);
        bus(1, tedet_pkg::OFF_LENGTH, len, tedet_pkg::RESP_OKAY, 0);
        bus(1, tedet_pkg::OFF_PAT_LO, lo, tedet_pkg::RESP_OKAY, 0);
        bus(1, tedet_pkg::OFF_PAT_HI, hi, tedet_pkg::RESP_OKAY, 0);
        bus(1, tedet_pkg::OFF_SWITCH, {31'h0, sw[0]}, tedet_pkg::RESP_OKAY, 0);
    endtask
    // Mode pulse lands two edges after the last byte, so four edges settle it
    task automatic burst(input int dir, input string s, input int h0, input int h1, input int f);
        int m0, m1, tc;
        m0 = mcnt[0];
        m1 = mcnt[1];
        tc = tcnt[dir];
        peer_u.send(dir, s);
        repeat (4) @(posedge clk_sys_i);
        chk("mode0", h0, mcnt[0] - m0);
        chk("mode1", h1, mcnt[1] - m1);
        chk("forwarded", f, tcnt[dir] - tc);
        $display("Test burst %s done", s);
    endtask
    // A torn-down tunnel stays dead until it is taken down and set up again
    task automatic retun(input int t);
        @(posedge clk_sys_i);
        act[t] <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        act[t] <= 1'b1;
        @(posedge clk_sys_i);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        bus(0, tedet_pkg::OFF_SWITCH, 0, tedet_pkg::RESP_OKAY, 0);
        bus(0, tedet_pkg::OFF_LENGTH, 0, tedet_pkg::RESP_OKAY, 0);
        bus(0, 8'h20, 0, tedet_pkg::RESP_SLVERR, 0);
        bus(1, tedet_pkg::OFF_STATUS, 1, tedet_pkg::RESP_SLVERR, 0);
        act <= 2'b11;
        bus(1, tedet_pkg::OFF_IRQ_MASK, 3, tedet_pkg::RESP_OKAY, 0);
        cfg(4, 32'h6463_6261, 0, 1);
        burst(0, "xaabcdzz", 1, 0, 6);
        chk("irq", 1, {31'h0, irq});
        bus(0, tedet_pkg::OFF_IRQ_STAT, 0, tedet_pkg::RESP_OKAY, 1);
        bus(0, tedet_pkg::OFF_IRQ_STAT, 0, tedet_pkg::RESP_OKAY, 0);
        bus(0, tedet_pkg::OFF_STATUS, 0, tedet_pkg::RESP_OKAY, 32'h0001_0002);
        retun(0);
        burst(2, "ab", 0, 0, 2);
        burst(0, "cd", 0, 0, 2);
        burst(2, "cd", 0, 1, 2);
        retun(1);
        burst(0, "abc", 0, 0, 3);
        burst(1, "abcd", 1, 0, 4);
        retun(0);
        burst(0, "d", 0, 0, 1);
        cfg(1, 32'h0000_00aa, 0, 1);
        burst(3, "\252", 0, 1, 1);
        retun(1);
        cfg(8, 32'h4443_4241, 32'h4847_4645, 1);
        burst(1, "HGFEDCBA", 0, 0, 8);
        burst(1, "ABCDEFGH", 1, 0, 8);
        retun(0);
        cfg(9, 32'h4443_4241, 32'h4847_4645, 1);
        burst(0, "ABCDEFGH", 0, 0, 8);
        cfg(4, 32'h6463_6261, 0, 0);
        burst(2, "abcd", 0, 0, 4);
        bus(1, tedet_pkg::OFF_IRQ_MASK, 0, tedet_pkg::RESP_OKAY, 0);
        cfg(4, 32'h6463_6261, 0, 1);
        burst(2, "abcd", 0, 1, 4);
        chk("irq masked", 0, {31'h0, irq});
        bus(0, tedet_pkg::OFF_IRQ_STAT, 0, tedet_pkg::RESP_OKAY, 3);
        bus(0, tedet_pkg::OFF_COUNT, 0, tedet_pkg::RESP_OKAY, 6);
        $display("Test registers done");
        give_verdict();
    end
endmodule
